// ### design/watchdog_regs.vh
`ifndef WATCHDOG_REGS_VH
`define WATCHDOG_REGS_VH

// Register addresses (plain port, 8-bit address)
`define ADDR_PERIOD_SELECT  8'h00
`define ADDR_RESTART        8'h01
`define ADDR_STATUS         8'h02
`define ADDR_IRQ_MASK       8'h03
`define ADDR_COUNT_VIEW     8'h04

// Period select field
`define SEL_MSB             2
`define SEL_LSB             0
`define SEL_RESET           3'h0

// Restart key sequence
`define KEY_FIRST           8'h1E
`define KEY_SECOND          8'hE1

// Base counter
`define BASE_WIDTH          14
`define BASE_MAX            14'h3FFF
`define PRESCALE_STAGES     7

// Reset pulse length in peripheral clocks
`define RST_PULSE_CYCLES    7'd96

// Status bits
`define ST_OVERFLOW         0
`define ST_ENABLED          1
`define ST_WAKEHOLD         2

`endif

// ### design/watchdog_timeout_and_sleep_control.v
// Local design decisions: strobed register access and the placing of the registers.
`include "watchdog_regs.vh"

//Contract
//RULE_01 - The period select register holds a three-bit select in bits 2..0, upper bits reserved.
//RULE_02 - Reset clears the select bits to zero, choosing the shortest period.
//RULE_03 - In power-down the oscillator stops, so the counter holds still.
//RULE_04 - After a hardware-reset exit from power-down, software services the watchdog as usual.
//RULE_05 - An interrupt wake source holds its low input until the oscillator is stable.
//RULE_06 - After interrupt wake-up the counter stays stopped while the wake input is low.
//RULE_07 - Software should restart the watchdog in the wake-up interrupt routine.
//RULE_08 - Software should restart the watchdog just before entering power-down.
//RULE_09 - In idle the watchdog runs, so software must wake periodically to service it.
//RULE_10 - The base counter is 14 bits, counts machine cycles, and resets the device at 3FFF.
//RULE_11 - A seven-stage binary prescaler sits ahead of the base counter.
//RULE_12 - Writing 1E then E1 to the restart register enables or restarts it; only reset disables.
//RULE_13 - Overflow drives a low reset pulse lasting 96 peripheral clocks.
//RULE_14 - Each select step doubles the period: 16384 times two to the select, in machine cycles.
module watchdog_timeout_and_sleep_control #(
	parameter PULSE_CYCLES = 96
) (
	// Clock and reset
	input  wire       clk,
	input  wire       reset,
	// Machine-cycle enable and sleep state
	input  wire       machineCycle,
	input  wire       powerDown,
	input  wire       wakeIntN,
	// Register port
	input  wire [7:0] addr,
	input  wire [7:0] wrData,
	input  wire       wrStrobe,
	input  wire       rdStrobe,
	output reg  [7:0] rdData,
	// Outputs
	output reg        resetOutN,
	output reg        irq
);

	reg  [2:0]                     periodSel_q;
	reg                            enabled_q;
	reg                            keyArmed_q;
	reg  [`PRESCALE_STAGES-1:0]    prescale_q;
	reg  [`BASE_WIDTH-1:0]         base_q;
	reg                            wakeHold_q;
	reg  [6:0]                     pulseCnt_q;
	reg  [2:0]                     status_q;
	reg  [2:0]                     mask_q;
	reg  [`PRESCALE_STAGES-1:0]    preMask;
	reg  [2:0]                     statusSet;
	wire                           wrSel;
	wire                           wrKey;
	wire                           restart;
	wire                           running;
	wire                           preTick;
	wire                           overflow;
	wire                           pulseActive;

	assign wrSel   = wrStrobe && (addr == `ADDR_PERIOD_SELECT);
	assign wrKey   = wrStrobe && (addr == `ADDR_RESTART);
	assign restart = wrKey && keyArmed_q && (wrData == `KEY_SECOND); // RULE_12
	// Counter frozen in power-down and while wake input held low after a power-down wake
	assign running = enabled_q && machineCycle && !powerDown && !wakeHold_q; // RULE_03 RULE_06
	assign pulseActive = (pulseCnt_q != 7'h00);

	// Prescaler taps: select value s uses the low s prescaler bits
	always @* begin
		preMask = {`PRESCALE_STAGES{1'b0}};
		case (periodSel_q)
			3'h0: preMask = 7'h00;
			3'h1: preMask = 7'h01;
			3'h2: preMask = 7'h03;
			3'h3: preMask = 7'h07;
			3'h4: preMask = 7'h0F;
			3'h5: preMask = 7'h1F;
			3'h6: preMask = 7'h3F;
			3'h7: preMask = 7'h7F;
			default: preMask = 7'h00;
		endcase
	end

	assign preTick  = running && ((prescale_q & preMask) == preMask); // RULE_11 RULE_14
	assign overflow = preTick && (base_q == `BASE_MAX); // RULE_10

	always @* begin
		statusSet = 3'h0;
		statusSet[`ST_OVERFLOW] = overflow;
		statusSet[`ST_WAKEHOLD] = powerDown && !wakeIntN;
		statusSet[`ST_ENABLED]  = restart && !enabled_q;
	end

	// Select register
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			periodSel_q <= `SEL_RESET; // RULE_02
		end else if (wrSel) begin
			periodSel_q <= wrData[`SEL_MSB:`SEL_LSB]; // RULE_01
		end
	end

	// Key sequence and enable
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			keyArmed_q <= 1'b0;
			enabled_q  <= 1'b0;
		end else begin
			if (wrKey) begin
				keyArmed_q <= (wrData == `KEY_FIRST);
			end
			if (restart) begin
				enabled_q <= 1'b1; // RULE_12
			end
		end
	end

	// Wake hold: set on interrupt wake, released when input returns high
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wakeHold_q <= 1'b0;
		end else begin
			if (powerDown && !wakeIntN) begin
				wakeHold_q <= 1'b1; // RULE_05 RULE_06
			end else if (wakeIntN) begin
				wakeHold_q <= 1'b0; // RULE_06
			end
		end
	end

	// Prescaler and base counter
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prescale_q <= {`PRESCALE_STAGES{1'b0}};
			base_q     <= {`BASE_WIDTH{1'b0}};
		end else if (restart || overflow) begin
			prescale_q <= {`PRESCALE_STAGES{1'b0}};
			base_q     <= {`BASE_WIDTH{1'b0}};
		end else if (running) begin
			prescale_q <= prescale_q + 7'h01; // RULE_11
			if (preTick) begin
				base_q <= base_q + 14'h0001; // RULE_10
			end
		end
	end

	// Reset-out pulse, counted in peripheral clocks
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pulseCnt_q <= 7'h00;
			resetOutN  <= 1'b1;
		end else begin
			if (overflow) begin
				pulseCnt_q <= PULSE_CYCLES[6:0]; // RULE_13
			end else if (pulseActive) begin
				pulseCnt_q <= pulseCnt_q - 7'h01;
			end
			resetOutN <= !(overflow || (pulseCnt_q > 7'h01)); // RULE_13
		end
	end

	// Sticky status, write one to clear; set wins
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			status_q <= 3'h0;
			mask_q   <= 3'h0;
			irq      <= 1'b0;
		end else begin
			if (wrStrobe && (addr == `ADDR_STATUS)) begin
				status_q <= (status_q & ~wrData[2:0]) | statusSet;
			end else begin
				status_q <= status_q | statusSet;
			end
			if (wrStrobe && (addr == `ADDR_IRQ_MASK)) begin
				mask_q <= wrData[2:0];
			end
			irq <= |((status_q | statusSet) & mask_q);
		end
	end

	// Read data, one cycle after strobe
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rdData <= 8'h00;
		end else if (rdStrobe) begin
			case (addr)
				`ADDR_PERIOD_SELECT: rdData <= {5'h00, periodSel_q};
				`ADDR_STATUS:        rdData <= {5'h00, status_q};
				`ADDR_IRQ_MASK:      rdData <= {5'h00, mask_q};
				`ADDR_COUNT_VIEW:    rdData <= {5'h00, wakeHold_q, keyArmed_q, enabled_q};
				default:             rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end

endmodule

// ### tb/watchdog_timeout_and_sleep_control_asserts.sv
module watchdog_asserts #(parameter PULSE_CYCLES = 96) (
	input wire       clk, reset, machineCycle, powerDown, wakeIntN,
	input wire [7:0] addr, wrData, rdData,
	input wire       wrStrobe, rdStrobe, resetOutN, irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_key;
		wrStrobe && addr == 8'h01 && wrData == 8'h1E ##1 wrStrobe && addr == 8'h01 && wrData == 8'hE1;
	endsequence
	sequence s_hold;
		powerDown && !wakeIntN ##1 rdStrobe && addr == 8'h04 && !wakeIntN;
	endsequence
	property p_sel; rdStrobe && addr == 8'h00 |=> rdData[7:3] == 5'h00; endproperty
	property p_wo; rdStrobe && addr == 8'h01 |=> rdData == 8'h00; endproperty
	property p_key; s_key ##1 rdStrobe && addr == 8'h04 |=> rdData[0]; endproperty
	property p_hold; s_hold |=> rdData[2]; endproperty
	property p_pulse; $fell(resetOutN) |-> ##95 !resetOutN ##1 resetOutN; endproperty
	property p_pd; $fell(resetOutN) |-> !($past(powerDown) && $past(powerDown, 2)); endproperty
	property p_mc; $fell(resetOutN) |-> $past(machineCycle) || $past(machineCycle, 2); endproperty
	property p_mask; wrStrobe && addr == 8'h03 && wrData == 8'h00 |-> ##2 !irq; endproperty
	a_sel: assert property (p_sel) else $error("reserved select bits");
	a_wo: assert property (p_wo) else $error("restart register readable");
	a_key: assert property (p_key) else $error("key did not enable");
	a_hold: assert property (p_hold) else $error("wake hold missing");
	a_pulse: assert property (p_pulse) else $error("reset pulse length");
	a_pd: assert property (p_pd) else $error("overflow in power-down");
	a_mc: assert property (p_mc) else $error("overflow without machine cycle");
	a_mask: assert property (p_mask) else $error("masked interrupt high");
endmodule

// ### tb/watchdog_timeout_and_sleep_control_tb.sv
module watchdog_timeout_and_sleep_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, reset = 1, machineCycle = 1, powerDown = 0, wakeIntN = 1;
	logic       wrStrobe = 0, rdStrobe = 0, resetOutN, irq;
	logic [7:0] addr = 8'h00, wrData = 8'h00, rdData;
	logic [7:0] rowIn [3] = '{8'hFF, 8'h0A, 8'hF8};
	logic [7:0] rowOut [3] = '{8'h07, 8'h02, 8'h00};
	int         bad_count = 0, total_checks = 0, n;
	watchdog_timeout_and_sleep_control dut_u (.*);
	initial forever #50 clk = ~clk;
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] g, e);
		total_checks++;
		if (g !== e) begin
			$display("unexpected %0t got %h want %h", $time, g, e);
			bad_count++;
		end
	endtask
	// Strobe stays up so back-to-back writes need no idle cycle between them
	task wr(input logic [7:0] a, d);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		rdStrobe <= 1'b0;
		@(posedge clk);
	endtask
	task idle(input int c);
		wrStrobe <= 1'b0;
		repeat (c) @(posedge clk);
	endtask
	// Read data checked at the edge closing the cycle it stands in
	task rd(input logic [7:0] a, e);
		addr <= a;
		rdStrobe <= 1'b1;
		wrStrobe <= 1'b0;
		@(posedge clk);
		rdStrobe <= 1'b0;
		@(posedge clk);
		chk(rdData, e);
	endtask
	// Cycles until the reset pulse, then let it finish
	task ovf;
		n = 0;
		while (resetOutN !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		chk({7'h00, n > 16369 && n < 16391}, 8'h01);
		if (n == 20000)
			complete_run;
		repeat (100) @(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(8'h00, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, rowIn[i]);
			rd(8'h00, rowOut[i]);
		end
		rd(8'h01, 8'h00);
		wr(8'h7F, 8'hFF);
		rd(8'h7F, 8'h00);
		$display("register test done");
		wr(8'h03, 8'h01);
		wr(8'h01, 8'h1E);
		wr(8'h01, 8'hE1);
		rd(8'h04, 8'h01);
		ovf;
		chk({7'h00, irq}, 8'h01);
		wr(8'h03, 8'h00);
		idle(2);
		chk({7'h00, irq}, 8'h00);
		wr(8'h03, 8'h01);
		wr(8'h02, 8'h03);
		idle(2);
		chk({7'h00, irq}, 8'h00);
		$display("overflow test done");
		wr(8'h01, 8'h1E);
		wr(8'h01, 8'hE1);
		powerDown <= 1'b1;
		wakeIntN <= 1'b0;
		idle(16000);
		rd(8'h04, 8'h05);
		powerDown <= 1'b0;
		repeat (1000) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		wakeIntN <= 1'b1;
		wr(8'h01, 8'h1E);
		wr(8'h01, 8'hE1);
		idle(1);
		ovf;
		$display("sleep test done");
		powerDown <= 1'b1;
		reset <= 1'b1;
		idle(2);
		reset <= 1'b0;
		powerDown <= 1'b0;
		idle(1);
		rd(8'h04, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h1E);
		wr(8'h01, 8'hE1);
		rd(8'h04, 8'h01);
		$display("reset test done");
		complete_run;
	end
endmodule
bind watchdog_timeout_and_sleep_control watchdog_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (.*);
